// File: pkg/bsu_defines.vh
// constants for the branch and skip unit
// Functional notes
// - compare immediate sets flags, discards difference
// - skip on register bit clear
// - skip on register bit set
// - skip on i/o bit clear
// - skip on i/o bit set, any length
// - branch if chosen flag set, pc+k+1
// - branch if chosen flag clear, 1/2 cycles
// - carry branches, no flags altered
// - same-or-higher/lower reuse carry test
// - signed ge/lt branches keep flags unchanged
// - half carry branches on H flag
`ifndef BSU_DEFINES_VH
`define BSU_DEFINES_VH
// operation codes presented by decode
`define BSU_OP_NONE       5'h00
`define BSU_OP_CMPI       5'h01
`define BSU_OP_CMPC       5'h02
`define BSU_OP_SKRC       5'h03
`define BSU_OP_SKRS       5'h04
`define BSU_OP_SKIC       5'h05
`define BSU_OP_SKIS       5'h06
`define BSU_OP_BFS        5'h07
`define BSU_OP_BFC        5'h08
`define BSU_OP_BNE        5'h09
`define BSU_OP_BCS        5'h0A
`define BSU_OP_BCC        5'h0B
`define BSU_OP_BSH        5'h0C
`define BSU_OP_BLO        5'h0D
`define BSU_OP_BMI        5'h0E
`define BSU_OP_BPL        5'h0F
`define BSU_OP_BGE        5'h10
`define BSU_OP_BLT        5'h11
`define BSU_OP_BHS        5'h12
`define BSU_OP_BHC        5'h13
`define BSU_OP_BTS        5'h14
// status flag bit positions
`define BSU_FLG_C         0
`define BSU_FLG_Z         1
`define BSU_FLG_N         2
`define BSU_FLG_V         3
`define BSU_FLG_S         4
`define BSU_FLG_H         5
`define BSU_FLG_T         6
`define BSU_FLG_I         7
// pc advance amounts in words
`define BSU_PC_STEP       2'h1
`define BSU_SKIP_SHORT    2'h2
`define BSU_SKIP_LONG     2'h3
// cycles an operation takes
`define BSU_CYC_ONE       2'h1
`define BSU_CYC_TWO       2'h2
`define BSU_CYC_THREE     2'h3
`endif

// File: src/bsu_cmp.v
// flag computation for the compare operations
`timescale 1ns/1ps
`default_nettype none
module bsu_cmp #(
	parameter W = 8
) (
	input  wire [W-1:0] dst,     // destination operand
	input  wire [W-1:0] src,     // constant or source register
	input  wire         cin,     // borrow in (compare with carry)
	input  wire         zin,     // previous zero flag
	input  wire         chain,   // 1: zero flag chains from zin
	output wire [W-1:0] diff,    // difference, not stored
	output wire         f_z,     // zero
	output wire         f_n,     // negative
	output wire         f_v,     // overflow
	output wire         f_c,     // carry (borrow)
	output wire         f_h      // half carry
);
	wire [W:0] full;
	// subtract with borrow, keep borrow out
	assign full = {1'b0, dst} - {1'b0, src} - {{W{1'b0}}, cin};
	assign diff = full[W-1:0];
	assign f_n  = diff[W-1];
	assign f_c  = (~dst[W-1] & src[W-1]) | (src[W-1] & diff[W-1]) | (diff[W-1] & ~dst[W-1]);
	assign f_h  = (~dst[3] & src[3]) | (src[3] & diff[3]) | (diff[3] & ~dst[3]);
	assign f_v  = (dst[W-1] & ~src[W-1] & ~diff[W-1]) | (~dst[W-1] & src[W-1] & diff[W-1]);
	assign f_z  = (diff == {W{1'b0}}) & (~chain | zin);
endmodule
`default_nettype wire

// File: src/bsu_top.v
// branch, skip and compare control-flow unit of the core
`timescale 1ns/1ps
`default_nettype none
`include "bsu_defines.vh"
module bsu_top #(
	parameter PCW = 16
) (
	input  wire           clk,          // core clock, 200 MHz
	input  wire           sys_rst,      // synchronous reset, active high
	input  wire           op_valid,     // decoded operation present, one cycle
	input  wire [4:0]     op_code,      // operation code
	input  wire [PCW-1:0] pc_in,        // address of the current instruction
	input  wire [6:0]     rel_k,        // signed branch offset
	input  wire [2:0]     sel_bit,      // bit or flag select
	input  wire [7:0]     reg_data,     // destination / tested register
	input  wire [7:0]     imm_data,     // constant or second register
	input  wire [7:0]     io_data,      // addressed i/o register value
	input  wire           next_long,    // following instruction is two words
	input  wire [7:0]     flags_in,     // current status flags
	output reg            pc_load,      // pulse: load pc with pc_next
	output reg  [PCW-1:0] pc_next,      // new program counter
	output reg  [1:0]     op_cycles,    // cycles this operation takes
	output reg            flags_we,     // pulse: write flags_out
	output reg  [7:0]     flags_out,    // updated status flags
	output reg            busy          // high while extra cycles run
);
	wire       cz, cn, cv, cc, ch;
	reg        take;
	reg        is_br;
	reg        is_skip;
	reg        is_cmp;
	reg  [1:0] stall_r;
	wire       fs;
	wire       cmp_carry;

	assign cmp_carry = (op_code == `BSU_OP_CMPC);
	assign fs  = flags_in[`BSU_FLG_N] ^ flags_in[`BSU_FLG_V];

	// flag arithmetic; difference is never stored
	bsu_cmp #(.W(8)) u_cmp (
		.dst   (reg_data),
		.src   (imm_data),
		.cin   (cmp_carry & flags_in[`BSU_FLG_C]),
		.zin   (flags_in[`BSU_FLG_Z]),
		.chain (cmp_carry),
		.diff  (),             // difference is never stored
		.f_z   (cz),
		.f_n   (cn),
		.f_v   (cv),
		.f_c   (cc),
		.f_h   (ch)
	);

	// condition decode per operation
	always @* begin
		take    = 1'b0;
		is_br   = 1'b0;
		is_skip = 1'b0;
		is_cmp  = 1'b0;
		case (op_code)
			`BSU_OP_CMPI, `BSU_OP_CMPC: begin
				is_cmp = 1'b1;
			end
			`BSU_OP_SKRC: begin
				is_skip = 1'b1;
				take    = ~reg_data[sel_bit];
			end
			`BSU_OP_SKRS: begin
				is_skip = 1'b1;
				take    = reg_data[sel_bit];
			end
			`BSU_OP_SKIC: begin
				is_skip = 1'b1;
				take    = ~io_data[sel_bit];
			end
			`BSU_OP_SKIS: begin
				is_skip = 1'b1;
				take    = io_data[sel_bit];
			end
			`BSU_OP_BFS: begin
				is_br = 1'b1;
				take  = flags_in[sel_bit];
			end
			`BSU_OP_BFC: begin
				is_br = 1'b1;
				take  = ~flags_in[sel_bit];
			end
			`BSU_OP_BNE: begin
				is_br = 1'b1;
				take  = ~flags_in[`BSU_FLG_Z];
			end
			`BSU_OP_BCS, `BSU_OP_BLO: begin
				is_br = 1'b1;
				take  = flags_in[`BSU_FLG_C];
			end
			`BSU_OP_BCC, `BSU_OP_BSH: begin
				is_br = 1'b1;
				take  = ~flags_in[`BSU_FLG_C];
			end
			`BSU_OP_BMI: begin
				is_br = 1'b1;
				take  = flags_in[`BSU_FLG_N];
			end
			`BSU_OP_BPL: begin
				is_br = 1'b1;
				take  = ~flags_in[`BSU_FLG_N];
			end
			`BSU_OP_BGE: begin
				is_br = 1'b1;
				take  = ~fs;
			end
			`BSU_OP_BLT: begin
				is_br = 1'b1;
				take  = fs;
			end
			`BSU_OP_BHS: begin
				is_br = 1'b1;
				take  = flags_in[`BSU_FLG_H];
			end
			`BSU_OP_BHC: begin
				is_br = 1'b1;
				take  = ~flags_in[`BSU_FLG_H];
			end
			`BSU_OP_BTS: begin
				is_br = 1'b1;
				take  = flags_in[`BSU_FLG_T];
			end
			default: begin
				take = 1'b0;
			end
		endcase
	end

	// signed offset widened to pc width
	wire [PCW-1:0] k_ext;
	assign k_ext = {{(PCW-7){rel_k[6]}}, rel_k};

	// candidate program counter values, all at pc width
	wire [PCW-1:0] pc_step;
	wire [PCW-1:0] pc_branch;
	wire [PCW-1:0] pc_skip;
	assign pc_step   = pc_in + {{(PCW-2){1'b0}}, `BSU_PC_STEP};
	assign pc_branch = pc_step + k_ext;
	assign pc_skip   = pc_in + {{(PCW-2){1'b0}}, (next_long ? `BSU_SKIP_LONG : `BSU_SKIP_SHORT)};

	// a skip over a two-word instruction costs one cycle more
	wire [1:0] skip_cycles;
	assign skip_cycles = next_long ? `BSU_CYC_THREE : `BSU_CYC_TWO;

	// compare result image: Z N V C H and S change, T and I pass
	wire [7:0] cmp_flags;
	assign cmp_flags = {flags_in[7:6], ch, cn ^ cv, cv, cn, cz, cc};

	// next values of the registered outputs and of the stall counter
	reg            pc_load_nxt;
	reg  [PCW-1:0] pc_next_nxt;
	reg  [1:0]     op_cycles_nxt;
	reg            flags_we_nxt;
	reg  [7:0]     flags_out_nxt;
	reg            busy_nxt;
	reg  [1:0]     stall_nxt;

	// pc_next, op_cycles and flags_out hold unless an op is accepted; pc_load and flags_we clear, busy clears except during a stall
	always @* begin
		pc_load_nxt   = 1'b0;
		pc_next_nxt   = pc_next;
		op_cycles_nxt = op_cycles;
		flags_we_nxt  = 1'b0;
		flags_out_nxt = flags_out;
		busy_nxt      = 1'b0;
		stall_nxt     = 2'h0;
		if (stall_r != 2'h0) begin
			// extra cycles of a taken branch or skip; requests are ignored
			stall_nxt = stall_r - 2'h1;
			busy_nxt  = (stall_r != 2'h1);
		end else if (op_valid) begin
			// every accepted op loads the pc, a plain step by default
			pc_load_nxt   = 1'b1;
			pc_next_nxt   = pc_step;
			op_cycles_nxt = `BSU_CYC_ONE;
			if (is_cmp) begin
				flags_we_nxt  = 1'b1;
				flags_out_nxt = cmp_flags;
			end
			if (is_br && take) begin
				// pc + k + 1, two cycles, flags untouched
				pc_next_nxt   = pc_branch;
				op_cycles_nxt = `BSU_CYC_TWO;
				stall_nxt     = `BSU_CYC_TWO - `BSU_CYC_ONE;
				busy_nxt      = 1'b1;
			end
			if (is_skip && take) begin
				// skip one or two words: pc + 2 or 3
				pc_next_nxt   = pc_skip;
				op_cycles_nxt = skip_cycles;
				stall_nxt     = skip_cycles - `BSU_CYC_ONE;
				busy_nxt      = 1'b1;
			end
		end
	end

	// registered outputs; every output leaves from a flip-flop
	always @(posedge clk) begin
		if (sys_rst) begin
			pc_load   <= 1'b0;
			pc_next   <= {PCW{1'b0}};
			op_cycles <= 2'h0;
			flags_we  <= 1'b0;
			flags_out <= 8'h00;
			busy      <= 1'b0;
			stall_r   <= 2'h0;
		end else begin
			pc_load   <= pc_load_nxt;
			pc_next   <= pc_next_nxt;
			op_cycles <= op_cycles_nxt;
			flags_we  <= flags_we_nxt;
			flags_out <= flags_out_nxt;
			busy      <= busy_nxt;
			stall_r   <= stall_nxt;
		end
	end
endmodule
`default_nettype wire

// File: dv/bsu_props.sv
// port checker for the branch and skip unit
`timescale 1ns/1ps
`default_nettype none
`include "bsu_defines.vh"
module bsu_props #(parameter PCW = 16) (
	input wire logic           clk,       // clock
	input wire logic           sys_rst,   // reset
	input wire logic           op_valid,  // request
	input wire logic [4:0]     op_code,   // op
	input wire logic [PCW-1:0] pc_in,     // pc
	input wire logic [6:0]     rel_k,     // offset
	input wire logic [2:0]     sel_bit,   // select
	input wire logic [7:0]     reg_data,  // register
	input wire logic [7:0]     imm_data,  // constant
	input wire logic [7:0]     io_data,   // i/o
	input wire logic           next_long, // long next
	input wire logic [7:0]     flags_in,  // flags
	input wire logic           pc_load,   // load
	input wire logic [PCW-1:0] pc_next,   // new pc
	input wire logic [1:0]     op_cycles, // cycles
	input wire logic           flags_we,  // write
	input wire logic [7:0]     flags_out, // new flags
	input wire logic           busy       // stall
);
	// accepted request and the targets it implies
	wire logic           acc = op_valid && !busy;
	wire logic           eqv = reg_data == imm_data;
	wire logic [PCW-1:0] tgt = pc_in + {{(PCW-7){rel_k[6]}}, rel_k} + 1'b1;
	wire logic [PCW-1:0] skp = pc_in + (next_long ? 2'h3 : 2'h2);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	AST_LOAD: assert property (acc |=> pc_load) else $error("no load");
	AST_IDLE: assert property (!acc |=> !pc_load) else $error("stray load");
	AST_CMP: assert property (acc && op_code == `BSU_OP_CMPI |=> flags_we
		&& flags_out[`BSU_FLG_Z] == $past(eqv)) else $error("compare flags");
	AST_NO_WE: assert property (acc && op_code > `BSU_OP_CMPC |=> !flags_we)
		else $error("flags written");
	AST_SKRC: assert property (acc && op_code == `BSU_OP_SKRC && !reg_data[sel_bit]
		|=> pc_next == $past(skp)) else $error("skip pc");
	AST_SKIS: assert property (acc && op_code == `BSU_OP_SKIS && io_data[sel_bit]
		|=> op_cycles == ($past(next_long) ? 2'h3 : 2'h2)) else $error("skip cycles");
	AST_BUSY: assert property (pc_load && op_cycles == 2'h3 |-> busy [*2] ##1 !busy)
		else $error("busy length");
	AST_BFS: assert property (acc && op_code == `BSU_OP_BFS && flags_in[sel_bit]
		|=> pc_next == $past(tgt)) else $error("branch pc");
	AST_SGE: assert property (acc && op_code == `BSU_OP_BGE && flags_in[2] == flags_in[3]
		|=> pc_next == $past(tgt) && op_cycles == 2'h2) else $error("signed branch");
endmodule
bind bsu_top bsu_props #(.PCW(PCW)) u_props (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid),
	.op_code(op_code), .pc_in(pc_in), .rel_k(rel_k), .sel_bit(sel_bit), .reg_data(reg_data),
	.imm_data(imm_data), .io_data(io_data), .next_long(next_long), .flags_in(flags_in),
	.pc_load(pc_load), .pc_next(pc_next), .op_cycles(op_cycles), .flags_we(flags_we),
	.flags_out(flags_out), .busy(busy));
`default_nettype wire

// File: dv/tb.sv
// self-checking bench of the branch and skip unit
`timescale 1ns/1ps
`default_nettype none
`include "bsu_defines.vh"
module tb;
	logic             clk = 1'b0, sys_rst = 1'b1, op_valid = 1'b0, next_long = 1'b0;
	logic [4:0]       op_code = 5'h00;
	logic [15:0]      pc_in = 16'h0000;
	logic [6:0]       rel_k = 7'h00;
	logic [2:0]       sel_bit = 3'h0;
	logic [7:0]       reg_data = 8'h00, imm_data = 8'h00, io_data = 8'h00, flags_in = 8'h00;
	wire logic        pc_load, flags_we, busy;
	wire logic [15:0] pc_next;
	wire logic [1:0]  op_cycles;
	wire logic [7:0]  flags_out;
	int               errors = 0, comparisons = 0;
	bsu_top #(.PCW(16)) dut (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid),
		.op_code(op_code), .pc_in(pc_in), .rel_k(rel_k), .sel_bit(sel_bit), .reg_data(reg_data),
		.imm_data(imm_data), .io_data(io_data), .next_long(next_long), .flags_in(flags_in),
		.pc_load(pc_load), .pc_next(pc_next), .op_cycles(op_cycles), .flags_we(flags_we),
		.flags_out(flags_out), .busy(busy));
	// 200 MHz clock
	always #2.5 clk = ~clk;
	// condition that makes a skip or branch happen
	function automatic logic take(input logic [4:0] c);
		case (c)
			`BSU_OP_SKRC: take = !reg_data[sel_bit];
			`BSU_OP_SKRS: take = reg_data[sel_bit];
			`BSU_OP_SKIC: take = !io_data[sel_bit];
			`BSU_OP_SKIS: take = io_data[sel_bit];
			`BSU_OP_BFS: take = flags_in[sel_bit];
			`BSU_OP_BFC: take = !flags_in[sel_bit];
			`BSU_OP_BNE: take = !flags_in[1];
			`BSU_OP_BCS, `BSU_OP_BLO: take = flags_in[0];
			`BSU_OP_BCC, `BSU_OP_BSH: take = !flags_in[0];
			`BSU_OP_BMI: take = flags_in[2];
			`BSU_OP_BPL: take = !flags_in[2];
			`BSU_OP_BGE: take = flags_in[2] == flags_in[3];
			`BSU_OP_BLT: take = flags_in[2] != flags_in[3];
			`BSU_OP_BHS: take = flags_in[5];
			`BSU_OP_BHC: take = !flags_in[5];
			`BSU_OP_BTS: take = flags_in[6];
			default: take = 1'b0;
		endcase
	endfunction
	// flags after a compare, difference thrown away
	function automatic logic [7:0] cmpf(input logic cc);
		logic [8:0] d;
		logic       n, v, h;
		d = {1'b0, reg_data} - {1'b0, imm_data} - 9'(cc & flags_in[0]);
		n = d[7];
		v = reg_data[7] & !imm_data[7] & !n | !reg_data[7] & imm_data[7] & n;
		h = !reg_data[3] & imm_data[3] | imm_data[3] & d[3] | d[3] & !reg_data[3];
		cmpf = {flags_in[7:6], h, n ^ v, v, n, d[7:0] == 8'h00 && (!cc || flags_in[1]), d[8]};
	endfunction
	// one comparison of a seen value against its expectation
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// final report and end of run
	task automatic test_done;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// issue one op, check the answer, optionally poke during the stall
	task automatic do_op(input logic [4:0] c, input logic poke);
		logic       t, sk, br, cp;
		logic [1:0] ec;
		int         n;
		t = take(c);
		sk = c >= `BSU_OP_SKRC && c <= `BSU_OP_SKIS;
		br = c >= `BSU_OP_BFS && c <= `BSU_OP_BTS;
		cp = c == `BSU_OP_CMPI || c == `BSU_OP_CMPC;
		ec = !t ? 2'h1 : (sk && next_long ? 2'h3 : 2'h2);
		op_code = c;
		op_valid = 1'b1;
		@(negedge clk);
		// a free unit takes the next op at once; a stalled one is poked or left alone
		if (busy === 1'b1)
			op_valid = poke;
		chk("pc_load", 16'h1, 16'(pc_load));
		chk("pc_next", br && t ? pc_in + {{9{rel_k[6]}}, rel_k} + 16'h1 : pc_in + ec, pc_next);
		chk("op_cycles", 16'(ec), 16'(op_cycles));
		chk("flags_we", 16'(cp), 16'(flags_we));
		if (cp)
			chk("flags_out", 16'(cmpf(c == `BSU_OP_CMPC)), 16'(flags_out));
		n = 0;
		while (busy === 1'b1) begin
			n++;
			if (n > 3) begin
				errors++;
				test_done;
			end
			@(negedge clk);
		end
		chk("busy", 16'(ec - 2'h1), 16'(n));
		if (poke && n > 0)
			chk("refused", 16'h0, 16'(pc_load));
	endtask
	// reset, every op code with corner fields, then random traffic and a second reset
	initial begin
		void'($urandom(32'h5947));
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		for (int i = 0; i < 600; i++) begin
			{reg_data, imm_data, io_data, flags_in} = $urandom;
			{pc_in, rel_k, sel_bit, next_long} = 27'($urandom);
			if (i < 44)
				{pc_in, rel_k} = {16'hFFFE, i[0] ? 7'h40 : 7'h3F};
			if (i % 7 == 0)
				imm_data = reg_data;
			do_op(i < 42 ? 5'(i % 21) : (i < 44 ? 5'h1F : 5'($urandom % 21)), i[1]);
		end
		sys_rst = 1'b1;
		@(negedge clk);
		chk("rst pc_next", 16'h0, pc_next);
		chk("rst busy", 16'h0, 16'(busy));
		sys_rst = 1'b0;
		do_op(`BSU_OP_BTS, 1'b1);
		test_done;
	end
endmodule
`default_nettype wire
